// ===== src/flr_pkg.sv
// flr_pkg: command codes, record layout, timing counts and carrier types
// for the fault-log recorder. assumes a 20 MHz core clock.
package flr_pkg;
    // command codes seen on the serial link
    localparam logic [7:0] CMD_LOG_READ  = 8'hEE;
    localparam logic [7:0] CMD_LOG_STORE = 8'hEA;
    localparam logic [7:0] CMD_LOG_ERASE = 8'hEC;
    localparam logic [7:0] CMD_EE_UNLOCK = 8'hBD;
    localparam logic [7:0] CMD_EE_ERASE  = 8'hBE;
    localparam logic [7:0] CMD_EE_DATA   = 8'hBF;

    // record geometry
    localparam logic [7:0] REC_LEN  = 8'h93;          // 147 bytes
    localparam int         REC_BITS = 32'h0000_0498;  // 147 * 8
    localparam int         PAGES    = 32'h0000_0006;

    // fault source codes, byte 4 of the record
    localparam logic [7:0] SRC_STORE    = 8'hFF;
    localparam logic [7:0] SRC_TON_MAX  = 8'h00;
    localparam logic [7:0] SRC_VOUT_OV  = 8'h01;
    localparam logic [7:0] SRC_VOUT_UV  = 8'h02;
    localparam logic [7:0] SRC_IOUT_OC  = 8'h03;
    localparam logic [7:0] SRC_TEMP_OT  = 8'h05;
    localparam logic [7:0] SRC_TEMP_UT  = 8'h06;
    localparam logic [7:0] SRC_VIN_OV   = 8'h07;
    localparam logic [7:0] SRC_DIE_OT   = 8'h0A;

    // bit positions
    localparam int CFG_LOG_EN_BIT = 32'h0000_0007;
    localparam int VSTAT_LOG_BIT  = 32'h0000_0003;

    // die temperature window for nvm lockout, whole degrees c
    localparam logic signed [15:0] TEMP_OFF_C = 16'sh0082;  // 130
    localparam logic signed [15:0] TEMP_ON_C  = 16'sh007D;  // 125

    // timing
    localparam int CLK_HZ     = 32'h0131_2D00;  // 20 MHz
    localparam int TICK_US    = 32'h0000_00C8;  // 200 us
    localparam int TICK_CYC   = CLK_HZ / 32'h000F_4240 * TICK_US;
    localparam int ERASE_MS   = 32'h0000_0008;  // 8 ms
    localparam int ERASE_CYC  = ERASE_MS * (CLK_HZ / 32'h0000_03E8);
    localparam int NVM_WR_CYC = 32'h0000_0040;

    typedef struct packed {
        logic [15:0] vout0;
        logic [15:0] vout1;
        logic [15:0] iout0;
        logic [15:0] iout1;
        logic [15:0] vin;
        logic [15:0] iin;
        logic [7:0]  svout0;
        logic [7:0]  svout1;
        logic [15:0] sword0;
        logic [15:0] sword1;
        logic [7:0]  svend0;
        logic [7:0]  svend1;
    } flr_page_t;

    typedef struct packed {
        logic [15:0] vout_pk0;
        logic [15:0] vout_pk1;
        logic [15:0] iout_pk0;
        logic [15:0] iout_pk1;
        logic [15:0] vin_pk;
        logic [15:0] temp_ext0;
        logic [15:0] temp_ext1;
        logic [15:0] temp_die;
    } flr_hdr_t;

    typedef struct packed {
        logic [7:0]             src;
        logic [47:0]            ts;
        flr_hdr_t               hdr;
        flr_page_t [0:PAGES-1]  pages;
    } flr_rec_t;

    typedef struct packed {
        logic [7:0]  cmd;
        logic        rd;
        logic        cont;
        logic [15:0] wdata;
    } flr_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        nack;
    } flr_resp_t;
endpackage

// ===== src/flr_fault_recorder.sv
// flr_fault_recorder: fault record capture, commit, erase and readout,
// plus the bulk user eeprom gate. assumes a link-side command decoder on
// lk_clk and telemetry/fault sources on clk.
`timescale 1ns/100ps

// Summary of operation
// [R1] record readable only after fault since erase
// [R2] no record: block length zero, no data
// [R3] record present: length 147 then 147 bytes
// [R4] record held until erase removes it; here reset drops it and a store command overwrites it
// [R5] early pages may be invalid after power-up
// [R6] store command captures exactly like a fault
// [R7] store sets status bit 3 if enabled
// [R8] nvm commands locked above 130, below 125
// [R9] bytes 0-3: two maker chars, factory word
// [R10] byte 4 holds fault source code
// [R11] bytes 5-10 timestamp, least byte first
// [R12] bytes 11-20 five peaks, high byte first
// [R13] bytes 21-26 three temperatures, high first
// [R14] finish current scan, then commit record
// [R15] six 20-byte pages, newest at 27
// [R16] page field order: volts, amps, status
// [R17] voltages 16-bit mantissa, others 11-bit linear
// [R18] erase command clears record and bit 3
// [R19] status bit clears within 8 ms
// [R20] unlock gates bulk erase and data
// [R21] bulk erase then sequential word data
// [R22] decode 0xEE, 0xEA, 0xEC, not paged
// [R23] writes to record read refused, fault raised
module flr_fault_recorder #(
    parameter int          ERASE_CYC  = flr_pkg::ERASE_CYC,
    parameter int          USER_WORDS = 16,
    parameter logic [7:0]  MAKER0     = 8'h5A,    // arbitrary
    parameter logic [7:0]  MAKER1     = 8'h5A,    // arbitrary
    parameter logic [15:0] FACTORY_ID = 16'h0000, // arbitrary
    parameter logic [7:0]  UNLOCK_KEY = 8'hA5     // arbitrary
) (
    input  wire logic              clk,             // core clock
    input  wire logic              reset,           // async, high
    input  wire logic              lk_clk,          // link clock
    input  wire logic              link_req,        // request pulse
    input  wire flr_pkg::flr_req_t link_cmd,        // request fields
    output logic                   link_busy,       // request in flight
    output logic                   link_done,       // answer pulse
    output flr_pkg::flr_resp_t     link_resp,       // answer data
    input  wire logic [7:0]        global_config,   // bit 7 log enable
    input  wire logic signed [15:0] die_temp_c,     // degrees c
    input  wire logic              fault_evt,       // fault pulse
    input  wire logic [7:0]        fault_src,       // fault code
    input  wire logic              page_valid,      // scan done pulse
    input  wire flr_pkg::flr_page_t page_in,        // finished scan
    input  wire flr_pkg::flr_hdr_t hdr_in,          // peaks and temps
    output logic [7:0]             vendor_status_byte, // bit 3 only
    output logic                   log_present,     // record exists
    output logic                   nvm_busy,        // scan, commit or erase
    output logic                   comm_fault       // refused write
);
    localparam int UW = $clog2(USER_WORDS);

    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_SCAN   = 2'b01,
        S_COMMIT = 2'b10,
        S_ERASE  = 2'b11
    } flr_state_t;

    typedef struct packed {
        flr_state_t                         st;
        logic [11:0]                        tick;
        logic [47:0]                        ts;
        logic                               hot;
        logic                               present;
        logic                               vstat3;
        logic [31:0]                        cnt;
        logic [7:0]                         psrc;
        logic [47:0]                        pts;
        flr_pkg::flr_page_t [0:flr_pkg::PAGES-1] hist;
        flr_pkg::flr_rec_t                  rec;
        logic [7:0]                         idx;
        flr_pkg::flr_resp_t                 resp;
        logic                               rq1;
        logic                               rq2;
        logic                               rqd;
        logic                               ack;
        logic [7:0]                         unlock;
        logic [UW-1:0]                      ptr;
        logic [0:USER_WORDS-1][15:0]        umem;
        logic                               cfault;
        logic                               busy;
    } flr_core_t;

    typedef struct packed {
        logic               rqt;
        logic               a1;
        logic               a2;
        logic               ad;
        logic               busy;
        logic               done;
        flr_pkg::flr_req_t  hold;
        flr_pkg::flr_resp_t resp;
    } flr_link_t;

    flr_core_t r_r;
    flr_core_t r_nxt;
    flr_link_t l_r;
    flr_link_t l_nxt;

    logic                           take;
    logic                           log_en;
    logic                           nvm_ok;
    logic                           unlocked;
    logic [flr_pkg::REC_BITS-1:0]   flat;
    logic [10:0]                    bitpos;

    assign take     = r_r.rq2 ^ r_r.rqd;
    assign log_en   = global_config[flr_pkg::CFG_LOG_EN_BIT];
    assign unlocked = (r_r.unlock == UNLOCK_KEY);

    // readout image of the stored record
    assign flat = {MAKER0, MAKER1, FACTORY_ID,          // see [R9]
                   r_r.rec.src,                         // see [R10]
                   r_r.rec.ts[7:0],   r_r.rec.ts[15:8], // see [R11]
                   r_r.rec.ts[23:16], r_r.rec.ts[31:24],
                   r_r.rec.ts[39:32], r_r.rec.ts[47:40],
                   r_r.rec.hdr,                         // see [R12] [R13]
                   r_r.rec.pages};                      // see [R15] [R16]
    assign bitpos = 11'(flr_pkg::REC_BITS - 1) - {r_r.idx, 3'b000};

    // core clock domain
    always_comb begin
        r_nxt = r_r;
        r_nxt.cfault = 1'b0;
        r_nxt.rq1 = l_r.rqt;
        r_nxt.rq2 = r_r.rq1;
        r_nxt.rqd = r_r.rq2;

        // 200 us timestamp tick
        if (r_r.tick == 12'(flr_pkg::TICK_CYC - 1)) begin
            r_nxt.tick = '0;
            r_nxt.ts   = r_r.ts + 48'h0000_0000_0001;
        end else begin
            r_nxt.tick = r_r.tick + 12'h001;
        end

        // hysteresis keeps the lock from chattering near the limit
        if (die_temp_c > flr_pkg::TEMP_OFF_C) begin
            r_nxt.hot = 1'b1;                           // see [R8]
        end else if (die_temp_c < flr_pkg::TEMP_ON_C) begin
            r_nxt.hot = 1'b0;                           // see [R8]
        end

        // history fills from reset; pages before it hold zeros
        if (page_valid) begin
            r_nxt.hist = {page_in, r_r.hist[0:flr_pkg::PAGES-2]}; // see [R5]
        end

        case (r_r.st)
            S_IDLE: begin
                // only the first fault since erase is logged
                if (fault_evt && log_en && !r_r.hot && !r_r.present) begin
                    r_nxt.psrc = fault_src;             // see [R1] [R10]
                    r_nxt.pts  = r_r.ts;                // see [R11]
                    r_nxt.st   = S_SCAN;
                end
            end
            S_SCAN: begin
                if (page_valid) begin                   // see [R14]
                    r_nxt.rec.src   = r_r.psrc;
                    r_nxt.rec.ts    = r_r.pts;
                    r_nxt.rec.hdr   = hdr_in;           // see [R17]
                    r_nxt.rec.pages = {page_in,
                        r_r.hist[0:flr_pkg::PAGES-2]};  // see [R15]
                    r_nxt.cnt = '0;
                    r_nxt.st  = S_COMMIT;
                end
            end
            S_COMMIT: begin
                if (r_r.cnt == 32'(flr_pkg::NVM_WR_CYC - 1)) begin
                    r_nxt.present = 1'b1;               // see [R4] [R14]
                    r_nxt.st      = S_IDLE;
                end else begin
                    r_nxt.cnt = r_r.cnt + 32'h0000_0001;
                end
            end
            S_ERASE: begin
                if (r_r.cnt == 32'(ERASE_CYC - 1)) begin
                    r_nxt.vstat3 = 1'b0;                // see [R19]
                    r_nxt.st     = S_IDLE;
                end else begin
                    r_nxt.cnt = r_r.cnt + 32'h0000_0001;
                end
            end
            default: r_nxt.st = S_IDLE;
        endcase

        // refuse while busy, on the last busy cycle too, so a commit
        // ending and an erase never meet in one cycle
        nvm_ok = !r_r.hot && (r_r.st == S_IDLE) && (r_nxt.st == S_IDLE);

        if (take) begin
            r_nxt.ack  = ~r_r.ack;
            r_nxt.resp = '0;
            case (l_r.hold.cmd)                         // see [R22]
                flr_pkg::CMD_LOG_READ: begin
                    if (!l_r.hold.rd) begin
                        r_nxt.resp.nack = 1'b1;         // see [R23]
                        r_nxt.cfault    = 1'b1;
                    end else if (!l_r.hold.cont) begin
                        r_nxt.idx = '0;
                        r_nxt.resp.rdata = r_r.present ?  // see [R2] [R3]
                            {8'h00, flr_pkg::REC_LEN} : 16'h0000;
                    end else if (r_r.present &&
                                 r_r.idx < flr_pkg::REC_LEN) begin
                        r_nxt.resp.rdata = {8'h00, flat[bitpos -: 8]};
                        r_nxt.idx = r_r.idx + 8'h01;    // see [R3]
                    end else begin
                        r_nxt.resp.nack = 1'b1;         // see [R2]
                    end
                end
                flr_pkg::CMD_LOG_STORE: begin
                    if (l_r.hold.rd || !nvm_ok) begin
                        r_nxt.resp.nack = 1'b1;         // see [R8]
                    end else if (log_en) begin
                        r_nxt.psrc   = flr_pkg::SRC_STORE; // see [R6]
                        r_nxt.pts    = r_r.ts;
                        r_nxt.st     = S_SCAN;
                        r_nxt.vstat3 = 1'b1;            // see [R7]
                    end
                end
                flr_pkg::CMD_LOG_ERASE: begin
                    if (l_r.hold.rd || !nvm_ok) begin
                        r_nxt.resp.nack = 1'b1;         // see [R8]
                    end else begin
                        r_nxt.present = 1'b0;           // see [R18]
                        r_nxt.rec     = '0;
                        r_nxt.cnt     = '0;
                        r_nxt.st      = S_ERASE;
                    end
                end
                flr_pkg::CMD_EE_UNLOCK: begin
                    if (l_r.hold.rd) begin
                        r_nxt.resp.rdata = {8'h00, r_r.unlock};
                    end else if (r_r.hot) begin
                        r_nxt.resp.nack = 1'b1;
                    end else begin
                        r_nxt.unlock = l_r.hold.wdata[7:0]; // see [R20]
                    end
                end
                flr_pkg::CMD_EE_ERASE: begin
                    if (r_r.hot || !unlocked) begin
                        r_nxt.resp.nack = 1'b1;         // see [R20] [R8]
                    end else if (l_r.hold.rd) begin
                        r_nxt.resp.rdata = 16'(r_r.ptr);
                    end else begin
                        r_nxt.umem = '1;                // see [R21]
                        r_nxt.ptr  = '0;
                    end
                end
                flr_pkg::CMD_EE_DATA: begin
                    if (r_r.hot || !unlocked) begin
                        r_nxt.resp.nack = 1'b1;         // see [R20] [R8]
                    end else begin
                        if (l_r.hold.rd) begin
                            r_nxt.resp.rdata = r_r.umem[r_r.ptr];
                        end else begin
                            r_nxt.umem[r_r.ptr] = l_r.hold.wdata;
                        end
                        r_nxt.ptr = r_r.ptr + UW'(1);   // see [R21]
                    end
                end
                default: r_nxt.resp.nack = 1'b1;
            endcase
        end
        r_nxt.busy = (r_nxt.st != S_IDLE);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // link clock domain: toggle handshake, answer held stable by core
    always_comb begin
        l_nxt      = l_r;
        l_nxt.done = 1'b0;
        l_nxt.a1   = r_r.ack;
        l_nxt.a2   = l_r.a1;
        l_nxt.ad   = l_r.a2;
        if (l_r.busy && (l_r.a2 != l_r.ad)) begin
            l_nxt.busy = 1'b0;
            l_nxt.done = 1'b1;
            l_nxt.resp = r_r.resp;
        end else if (link_req && !l_r.busy) begin
            l_nxt.hold = link_cmd;
            l_nxt.rqt  = ~l_r.rqt;
            l_nxt.busy = 1'b1;
        end
    end

    always_ff @(posedge lk_clk or posedge reset) begin
        if (reset) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign link_busy          = l_r.busy;
    assign link_done          = l_r.done;
    assign link_resp          = l_r.resp;
    assign log_present        = r_r.present;
    assign nvm_busy           = r_r.busy;
    assign comm_fault         = r_r.cfault;
    assign vendor_status_byte = {4'h0, r_r.vstat3, 3'h0};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    len_zero_a: assert property (  // see [R2]
        take && l_r.hold.cmd == flr_pkg::CMD_LOG_READ && l_r.hold.rd &&
        !l_r.hold.cont && !r_r.present
        |=> r_r.resp.rdata == 16'h0000 && !r_r.resp.nack)
        else $error("empty log did not give length zero");

    len_full_a: assert property (  // see [R3]
        take && l_r.hold.cmd == flr_pkg::CMD_LOG_READ && l_r.hold.rd &&
        !l_r.hold.cont && r_r.present
        |=> r_r.resp.rdata == 16'h0093 && r_r.idx == 8'h00)
        else $error("present log did not give length 147");

    read_end_a: assert property (  // see [R3]
        take && l_r.hold.cmd == flr_pkg::CMD_LOG_READ && l_r.hold.rd &&
        l_r.hold.cont && r_r.idx == flr_pkg::REC_LEN
        |=> r_r.resp.nack && $stable(r_r.idx))
        else $error("read past byte 146 not refused");

    store_flag_a: assert property (  // see [R7]
        take && l_r.hold.cmd == flr_pkg::CMD_LOG_STORE && !l_r.hold.rd &&
        r_r.st == S_IDLE && !r_r.hot && !fault_evt
        |=> vendor_status_byte[3] == $past(log_en || r_r.vstat3))
        else $error("store flag not tied to log enable");

    hot_lock_a: assert property (  // see [R8]
        take && r_r.hot && (l_r.hold.cmd == flr_pkg::CMD_LOG_STORE ||
        l_r.hold.cmd == flr_pkg::CMD_LOG_ERASE ||
        l_r.hold.cmd == flr_pkg::CMD_EE_DATA)
        |=> r_r.resp.nack &&
            (r_r.st != S_ERASE || $past(r_r.st) == S_ERASE))
        else $error("nvm command accepted while hot");

    hyst_hold_a: assert property (  // see [R8]
        r_r.hot && die_temp_c >= flr_pkg::TEMP_ON_C |=> r_r.hot)
        else $error("lock released above 125");

    scan_wait_a: assert property (  // see [R14]
        r_r.st == S_SCAN && !page_valid |=> r_r.st == S_SCAN)
        else $error("commit began before scan finished");

    commit_a: assert property (  // see [R1]
        $rose(r_r.present) |-> $past(r_r.st) == S_COMMIT &&
        $past(r_r.cnt) == 32'(flr_pkg::NVM_WR_CYC - 1))
        else $error("record appeared without a commit");

    erase_clr_a: assert property (  // see [R18]
        r_r.st == S_IDLE && take && !r_r.hot && !fault_evt &&
        l_r.hold.cmd == flr_pkg::CMD_LOG_ERASE && !l_r.hold.rd
        |=> !r_r.present ##1 r_r.st == S_ERASE)
        else $error("erase did not drop the record");

    wr_reject_a: assert property (  // see [R23]
        take && l_r.hold.cmd == flr_pkg::CMD_LOG_READ && !l_r.hold.rd
        |=> comm_fault && r_r.resp.nack ##1 !comm_fault)
        else $error("write to record read not refused");

    gate_a: assert property (  // see [R20]
        take && !unlocked && l_r.hold.cmd == flr_pkg::CMD_EE_DATA
        |=> r_r.resp.nack && $stable(r_r.ptr))
        else $error("bulk data passed while locked");

    link_done_a: assert property (
        @(posedge lk_clk) disable iff (reset)
        link_done |-> !link_busy ##1 !link_done)
        else $error("link answer malformed");

    store_cov: cover property (
        r_r.st == S_COMMIT ##1 r_r.st == S_IDLE && r_r.present);
    read_cov: cover property (
        take && l_r.hold.cont && r_r.idx == 8'h92);
    erase_cov: cover property (
        r_r.st == S_ERASE ##1 r_r.st == S_IDLE);
endmodule // flr_fault_recorder

// ===== testbench/flr_host_model.sv
// flr_host_model: link-side host issuing one request at a time.
// assumes the recorder's link port and a link clock from the bench.
`timescale 1ns/100ps
module flr_host_model (
    input  wire logic         lk_clk,    // link clock
    input  wire logic         link_busy, // request in flight
    input  wire logic         link_done, // answer pulse
    output flr_pkg::flr_req_t link_cmd,  // request fields
    output logic              link_req,  // request strobe
    output logic              hung       // answer never came
);
    initial begin
        link_cmd = '0;
        link_req = 1'b0;
        hung     = 1'b0;
    end
    // held until taken, then released to inverted junk
    task automatic xfer(input logic [7:0] c, input logic rd,
                        input logic ct, input logic [15:0] wd);
        int n;
        repeat ($urandom_range(0, 2)) @(posedge lk_clk);
        @(posedge lk_clk);
        #1;
        link_req = 1'b1;
        link_cmd = {c, rd, ct, wd};
        for (n = 0; n < 4 && link_busy !== 1'b1; n++) begin
            @(posedge lk_clk);
            #1;
        end
        if (n == 4) hung = 1'b1;
        link_req = 1'b0;
        link_cmd = ~link_cmd;
        for (n = 0; n < 40 && link_done !== 1'b1; n++) begin
            @(posedge lk_clk);
            #1;
        end
        if (n == 40) hung = 1'b1;
    endtask
endmodule // flr_host_model

// ===== testbench/test_fault_log_recorder.sv
// test_fault_log_recorder: self-checking bench for the recorder.
// assumes flr_pkg and the host model; erase time shortened to 20.
`timescale 1ns/100ps
module test_fault_log_recorder;
    localparam int ERC = 20;
    logic clk = 0, lk_clk = 0, reset = 1, link_req, link_busy, link_done;
    logic fault_evt = 0, page_valid = 0, log_present, nvm_busy;
    logic comm_fault, hung;
    logic [7:0] global_config = 8'h80, fault_src = 8'h00, vsb;
    logic signed [15:0] die_temp_c = 16'sh0019;
    flr_pkg::flr_req_t link_cmd;
    flr_pkg::flr_resp_t link_resp;
    flr_pkg::flr_page_t page_in = '0, p0, p1, p2;
    flr_pkg::flr_hdr_t hdr_in = '0;
    logic [17:0] notes[$], e;
    logic [7:0] codes[8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                             8'h05, 8'h06, 8'h07, 8'h0A};
    logic [15:0] w[16];
    int fail_count = 0, tests_run = 0, comm_n = 0, cyc = 0;
    logic [47:0] ets = '0;

    flr_fault_recorder #(.ERASE_CYC(ERC)) dut (.clk(clk), .reset(reset),
        .lk_clk(lk_clk), .link_req(link_req), .link_cmd(link_cmd),
        .link_busy(link_busy), .link_done(link_done),
        .link_resp(link_resp), .global_config(global_config),
        .die_temp_c(die_temp_c), .fault_evt(fault_evt),
        .fault_src(fault_src), .page_valid(page_valid),
        .page_in(page_in), .hdr_in(hdr_in), .vendor_status_byte(vsb),
        .log_present(log_present), .nvm_busy(nvm_busy),
        .comm_fault(comm_fault));
    flr_host_model host (.lk_clk(lk_clk), .link_busy(link_busy),
        .link_done(link_done), .link_cmd(link_cmd),
        .link_req(link_req), .hung(hung));

    always #25 clk = ~clk;
    initial #7 forever #15 lk_clk = ~lk_clk;
    always @(posedge clk) if (comm_fault === 1'b1) comm_n++;
    always @(posedge clk) if (!reset) cyc++;

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [17:0] seen, input logic [17:0] x);
        tests_run++;
        if (seen !== x) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, x);
        end
    endtask
    // answers are matched in order of issue, sampled mid-pulse
    always @(negedge lk_clk) if (link_done === 1'b1) begin
        if (notes.size() == 0) check(18'h3_FFFF, 18'h0_0000);
        else begin
            e = notes.pop_front();
            check({1'b0, link_resp}, e);
        end
    end
    task automatic req(input logic [7:0] c, input logic rd, ct,
                       input logic [15:0] wd, input logic [17:0] x);
        notes.push_back(x);
        host.xfer(c, rd, ct, wd);
        if (hung) begin
            fail_count++;
            test_done();
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic scan(input flr_pkg::flr_page_t p);
        page_in = p;
        page_valid = 1'b1;
        clks(1);
        page_valid = 1'b0;
        page_in = ~p;
    endtask
    task automatic fault(input logic [7:0] s);
        int n;
        fault_src = s;
        fault_evt = 1'b1;
        ets = 48'(cyc / flr_pkg::TICK_CYC);
        clks(1);
        fault_evt = 1'b0;
        check(nvm_busy, 1);
        scan(p0);
        for (n = 0; n < 300 && log_present !== 1'b1; n++) clks(1);
        if (n == 300) begin
            fail_count++;
            test_done();
        end
    endtask
    // timestamp bytes expected from the bench's own tick count
    task automatic read_rec(input int n, input logic [7:0] s);
        logic [flr_pkg::REC_BITS-1:0] img;
        img = {32'h5A5A_0000, s, ets[7:0], ets[15:8], ets[23:16],
               ets[31:24], ets[39:32], ets[47:40], hdr_in, p0, p2, p1,
               480'h0};
        req(8'hEE, 1, 0, 0, {9'h0, flr_pkg::REC_LEN, 1'b0});
        for (int i = 0; i < n; i++)
            req(8'hEE, 1, 1, 0, {9'h0,
                img[1175 - 8 * i -: 8], 1'b0});
    endtask
    task automatic erase();
        req(8'hEC, 0, 0, 0, 18'h0_0000);
        check(log_present, 0);
        clks(ERC + 2);
        check(vsb, 8'h00);
    endtask

    initial begin
        void'($urandom(68));
        p0 = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        p1 = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        p2 = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        hdr_in = {$urandom(), $urandom(), $urandom(), $urandom()};
        clks(3);
        reset = 0;
        req(8'hEE, 1, 0, 0, 18'h0_0000);
        req(8'hEE, 1, 1, 0, 18'h0_0001);
        req(8'hEE, 0, 0, 0, 18'h0_0001);
        clks(2);
        check(comm_n, 1);
        req(8'hBE, 0, 0, 0, 18'h0_0001);
        req(8'hBF, 1, 0, 0, 18'h0_0001);
        scan(p1);
        scan(p2);
        // let the timestamp tick twice before the first fault
        clks(9000);
        fault(8'h01);
        read_rec(147, 8'h01);
        req(8'hEE, 1, 1, 0, 18'h0_0001);
        check(vsb, 8'h00);
        foreach (codes[i]) begin
            erase();
            fault(codes[i]);
            read_rec(5, codes[i]);
        end
        erase();
        global_config = 8'h00;
        req(8'hEA, 0, 0, 0, 18'h0_0000);
        clks(3);
        check(vsb, 8'h00);
        global_config = 8'h80;
        req(8'hEA, 0, 0, 0, 18'h0_0000);
        check(vsb, 8'h08);
        // a fault during the store's capture must not change its source
        fault(8'h03);
        read_rec(5, 8'hFF);
        die_temp_c = 16'sh0083;
        clks(4);
        req(8'hEA, 0, 0, 0, 18'h0_0001);
        die_temp_c = 16'sh0080;
        clks(4);
        req(8'hEC, 0, 0, 0, 18'h0_0001);
        die_temp_c = 16'sh007C;
        clks(4);
        erase();
        req(8'hEE, 1, 0, 0, 18'h0_0000);
        req(8'hBD, 0, 0, 16'h00A5, 18'h0_0000);
        req(8'hBD, 1, 0, 0, {9'h0, 8'hA5, 1'b0});
        req(8'hBE, 0, 0, 0, 18'h0_0000);
        req(8'hBF, 1, 0, 0, {1'b0, 16'hFFFF, 1'b0});
        req(8'hBE, 0, 0, 0, 18'h0_0000);
        foreach (w[i]) begin
            w[i] = 16'($urandom());
            req(8'hBF, 0, 0, w[i], 18'h0_0000);
        end
        req(8'hBE, 1, 0, 0, 18'h0_0000);
        foreach (w[i]) req(8'hBF, 1, 0, 0, {1'b0, w[i], 1'b0});
        clks(10);
        test_done();
    end
    initial begin
        #2ms;
        fail_count++;
        test_done();
    end
endmodule // test_fault_log_recorder
